/* shared/rce_regs.svh */
// register offsets, command codes, error codes and limits of the interpreter
`ifndef RCE_REGS_SVH
`define RCE_REGS_SVH

// register byte offsets
`define RCE_OFS_CMD 6'h00
`define RCE_OFS_RESP 6'h04
`define RCE_OFS_ERR 6'h08
`define RCE_OFS_STB 6'h0C
`define RCE_OFS_STA 6'h10
`define RCE_OFS_ALARM 6'h14
`define RCE_OFS_READY 6'h18
`define RCE_OFS_SRQ_MASK 6'h1C

// command word fields
`define RCE_CMD_OP_LSB 0
`define RCE_CMD_IDX_LSB 8
`define RCE_CMD_ARG_LSB 16

// command codes
`define RCE_OP_SERIAL_SET 8'h01
`define RCE_OP_SERIAL_QRY 8'h02
`define RCE_OP_LOCK_SET 8'h03
`define RCE_OP_LOCK_QRY 8'h04
`define RCE_OP_FW_QRY 8'h05
`define RCE_OP_ADR_SET 8'h06
`define RCE_OP_ADR_QRY 8'h07
`define RCE_OP_JITTER 8'h08
`define RCE_OP_SELF_TEST 8'h09
`define RCE_OP_GATE_START 8'h0A
`define RCE_OP_GATE_STOP 8'h0B
`define RCE_OP_CLEAR 8'h0C

// status byte bit positions
`define RCE_STB_FPS 2
`define RCE_STB_LCL 3
`define RCE_STB_RDY 4
`define RCE_STB_ERR 5
`define RCE_STB_RQS 6
`define RCE_READY_DRO 3

// error codes, 16-bit two's complement
`define RCE_E_UNKNOWN 16'hFF9C
`define RCE_E_CMDBUF_OVF 16'hFF73
`define RCE_E_CR_NO_LF 16'hFF69
`define RCE_E_PARITY 16'hFF60
`define RCE_E_FRAMING 16'hFF5F
`define RCE_E_UART_OVR 16'hFF5E
`define RCE_E_IBUF_OVR 16'hFF5D
`define RCE_E_RANGE 16'hFF2C
`define RCE_E_GATING 16'hFF06
`define RCE_E_NOT_GATING 16'hFF05
`define RCE_E_ZERO_PERIOD 16'hFF04
`define RCE_E_START_BUSY 16'hFF03
`define RCE_E_JGEN_OOR 16'hFEFC
`define RCE_E_DEV_FAIL 16'hFED4
`define RCE_E_ROM_CSUM 16'hFEBF
`define RCE_E_NO_JITTER 16'h0258
`define RCE_E_RS232_ONLY 16'h0260

// limits
`define RCE_ST_CODE_MIN 16'h0001
`define RCE_ST_CODE_MAX 16'h0257
`define RCE_ADR_MAX 16'h001E
`define RCE_FLOW_MAX 16'h0003
`define RCE_FLOW_IDX 4'h9
`define RCE_SERIAL_N 4'hA
`define RCE_LF 8'h0A
`define RCE_CR 8'h0D
`define RCE_FW_REV_DEF 16'h08FD
`define RCE_ERRQ_AW 3

`endif

/* shared/rce_pkg.sv */
// types shared by the command interpreter
package rce_pkg;
    typedef logic [15:0] rce_code_t;
    typedef logic [7:0] rce_op_t;
endpackage

/* hdl/rce_cmd_interp.sv */
// remote command interpreter with error queue and status registers
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - serial query returns all ten settings; flow value 3 means rx+tx
// - lock argument 1 disables all keys but power; 0 releases
// - lock query answers 0 or 1
// - firmware query answers yyww, years since 1960, 2301..9952
// - bus address set takes 0..30, only when controlled over serial
// - bus address query answers 0..30
// - jitter subtest: 0 all, 1 clock, 2 data, 4 filter
// - parse faults reported -100..-199, -100 unknown, -141 overflow
// - carriage return not followed by line feed gives -151
// - serial receive faults give -160..-163
// - execution faults -200..-299, -212 argument out of range
// - gating conflicts give -250, -251, -252, -253
// - jitter command ignored with -260 when generator out of range
// - hardware faults -300..-399, -321 for rom checksum
// - self test failures 1..599; power-on tests report nothing
// - missing option or capability rejected with 600..699, 608
// - controller reads recorded errors through the error query
// - four status registers: status byte, A, alarm, ready
// - status registers readable whichever link is in control
// - service request only on the instrument bus link
// - status bit 5 set on any error, cleared by clear or dev clear
//////////////////////////////////////////////////////////////////////////////
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`include "rce_regs.svh"

module rce_cmd_interp
    import rce_pkg::*;
#(
    parameter logic [15:0] FW_REV = `RCE_FW_REV_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // character stream and serial receive faults
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_parity_err,
    input wire logic rx_framing_err,
    input wire logic rx_uart_ovr,
    input wire logic rx_ibuf_ovr,
    input wire logic cmdbuf_ovf,
    // instrument state
    input wire logic remote_gpib,
    input wire logic gating,
    input wire logic gate_period_zero,
    input wire logic start_blocked,
    input wire logic jitter_cap,
    input wire logic jgen_oor,
    input wire logic hw_fault,
    input wire logic rom_csum_fail,
    input wire logic dev_clear,
    // self test results
    input wire logic st_done,
    input wire logic st_fail,
    input wire logic st_power_on,
    input wire logic [15:0] st_code,
    // status inputs
    input wire logic [7:0] status_a_in,
    input wire logic [7:0] alarm_in,
    input wire logic [7:0] ready_in,
    input wire logic [2:0] stb_misc_in,
    // front panel
    input wire logic key_press,
    input wire logic key_is_power,
    output logic key_accept,
    output logic key_locked,
    // actions
    output logic gate_start,
    output logic gate_stop,
    output logic jst_start,
    output logic [2:0] jst_sel,
    output logic st_start,
    output logic flow_sw_rx,
    output logic flow_sw_tx,
    output logic [4:0] bus_addr,
    output logic srq
);

    //////////////////////////////////////////////////////////////////////////
    // bus handshake: take when idle, answer one cycle later
    logic take;
    logic cmd_go;
    logic err_rd;
    logic resp_rd;
    logic stb_rd;
    logic mask_wr;
    assign take = (avs_read | avs_write) & avs_waitrequest;
    assign cmd_go = take & avs_write & (avs_address == `RCE_OFS_CMD);
    assign mask_wr = take & avs_write & (avs_address == `RCE_OFS_SRQ_MASK);
    assign err_rd = take & avs_read & (avs_address == `RCE_OFS_ERR);
    assign resp_rd = take & avs_read & (avs_address == `RCE_OFS_RESP);
    assign stb_rd = take & avs_read & (avs_address == `RCE_OFS_STB);

    rce_op_t op;
    logic [3:0] idx;
    logic [15:0] arg;
    assign op = avs_writedata[`RCE_CMD_OP_LSB +: 8];
    assign idx = avs_writedata[`RCE_CMD_IDX_LSB +: 4];
    assign arg = avs_writedata[`RCE_CMD_ARG_LSB +: 16];

    //////////////////////////////////////////////////////////////////////////
    // command decode and checks
    logic c_err;
    rce_code_t c_code;
    logic jst_legal;
    assign jst_legal = (arg == 16'h0000) | (arg == 16'h0001) |
                       (arg == 16'h0002) | (arg == 16'h0004);

    always_comb begin
        c_err = 1'b0;
        c_code = 16'h0000;
        if (cmd_go) begin
            unique case (op)
                `RCE_OP_SERIAL_SET: begin
                    if (idx >= `RCE_SERIAL_N ||
                        (idx == `RCE_FLOW_IDX && arg > `RCE_FLOW_MAX)) begin
                        c_err = 1'b1;
                        c_code = `RCE_E_RANGE;
                    end
                end
                `RCE_OP_LOCK_SET: begin
                    if (arg > 16'h0001) begin
                        c_err = 1'b1;
                        c_code = `RCE_E_RANGE;
                    end
                end
                `RCE_OP_ADR_SET: begin
                    if (remote_gpib) begin
                        c_err = 1'b1;
                        c_code = `RCE_E_RS232_ONLY;
                    end else if (arg > `RCE_ADR_MAX) begin
                        c_err = 1'b1;
                        c_code = `RCE_E_RANGE;
                    end
                end
                `RCE_OP_JITTER: begin
                    if (!jitter_cap) begin
                        c_err = 1'b1;
                        c_code = `RCE_E_NO_JITTER;
                    end else if (!jst_legal) begin
                        c_err = 1'b1;
                        c_code = `RCE_E_RANGE;
                    end else if (jgen_oor) begin
                        c_err = 1'b1;
                        c_code = `RCE_E_JGEN_OOR;
                    end
                end
                `RCE_OP_GATE_START: begin
                    c_err = gating | gate_period_zero | start_blocked;
                    if (gating) begin
                        c_code = `RCE_E_GATING;
                    end else if (gate_period_zero) begin
                        c_code = `RCE_E_ZERO_PERIOD;
                    end else if (start_blocked) begin
                        c_code = `RCE_E_START_BUSY;
                    end
                end
                `RCE_OP_GATE_STOP: begin
                    if (!gating) begin
                        c_err = 1'b1;
                        c_code = `RCE_E_NOT_GATING;
                    end
                end
                `RCE_OP_SERIAL_QRY, `RCE_OP_LOCK_QRY, `RCE_OP_FW_QRY,
                `RCE_OP_ADR_QRY, `RCE_OP_SELF_TEST, `RCE_OP_CLEAR: begin
                end
                default: begin
                    c_err = 1'b1;
                    c_code = `RCE_E_UNKNOWN;
                end
            endcase
        end
    end

    logic cmd_ok;
    assign cmd_ok = cmd_go & ~c_err;

    //////////////////////////////////////////////////////////////////////////
    // line terminator check
    logic cr_pend_reg;
    logic crlf_err;
    assign crlf_err = rx_valid & cr_pend_reg & (rx_char != `RCE_LF);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cr_pend_reg <= 1'b0;
        end else if (rx_valid) begin
            cr_pend_reg <= (rx_char == `RCE_CR);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // error source selection, one recorded per cycle
    logic st_err;
    assign st_err = st_done & st_fail & ~st_power_on &
                    (st_code >= `RCE_ST_CODE_MIN) &
                    (st_code <= `RCE_ST_CODE_MAX);

    logic err_valid;
    rce_code_t err_code;
    always_comb begin
        err_valid = 1'b1;
        err_code = 16'h0000;
        if (c_err) begin
            err_code = c_code;
        end else if (crlf_err) begin
            err_code = `RCE_E_CR_NO_LF;
        end else if (cmdbuf_ovf) begin
            err_code = `RCE_E_CMDBUF_OVF;
        end else if (rx_parity_err) begin
            err_code = `RCE_E_PARITY;
        end else if (rx_framing_err) begin
            err_code = `RCE_E_FRAMING;
        end else if (rx_uart_ovr) begin
            err_code = `RCE_E_UART_OVR;
        end else if (rx_ibuf_ovr) begin
            err_code = `RCE_E_IBUF_OVR;
        end else if (rom_csum_fail) begin
            err_code = `RCE_E_ROM_CSUM;
        end else if (hw_fault) begin
            err_code = `RCE_E_DEV_FAIL;
        end else if (st_err) begin
            err_code = st_code;
        end else begin
            err_valid = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // error queue; a full queue drops the newest code
    localparam int ERRQ_D = 1 << `RCE_ERRQ_AW;
    rce_code_t err_mem [ERRQ_D];
    logic [`RCE_ERRQ_AW:0] wr_ptr_reg;
    logic [`RCE_ERRQ_AW:0] rd_ptr_reg;
    logic q_empty;
    logic q_full;
    logic q_push;
    logic q_pop;
    assign q_empty = (wr_ptr_reg == rd_ptr_reg);
    assign q_full = (wr_ptr_reg[`RCE_ERRQ_AW] != rd_ptr_reg[`RCE_ERRQ_AW]) &&
        (wr_ptr_reg[`RCE_ERRQ_AW-1:0] == rd_ptr_reg[`RCE_ERRQ_AW-1:0]);
    assign q_push = err_valid & ~q_full;
    assign q_pop = err_rd & ~q_empty;

    always_ff @(posedge core_clk) begin
        if (q_push) begin
            err_mem[wr_ptr_reg[`RCE_ERRQ_AW-1:0]] <= err_code;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (q_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (q_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // settings
    logic [15:0] serial_reg [`RCE_SERIAL_N];
    logic [15:0] flow_val;
    assign flow_val = serial_reg[`RCE_FLOW_IDX];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `RCE_SERIAL_N; i++) begin
                serial_reg[i] <= 16'h0000;
            end
        end else if (cmd_ok && op == `RCE_OP_SERIAL_SET) begin
            serial_reg[idx] <= arg;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            key_locked <= 1'b0;
            bus_addr <= 5'h00;
            flow_sw_rx <= 1'b0;
            flow_sw_tx <= 1'b0;
        end else begin
            if (cmd_ok && op == `RCE_OP_LOCK_SET) begin
                key_locked <= arg[0];
            end
            if (cmd_ok && op == `RCE_OP_ADR_SET) begin
                bus_addr <= arg[4:0];
            end
            flow_sw_rx <= (flow_val == 16'h0001) | (flow_val == 16'h0003);
            flow_sw_tx <= (flow_val == 16'h0002) | (flow_val == 16'h0003);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // action pulses and front panel
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_start <= 1'b0;
            gate_stop <= 1'b0;
            jst_start <= 1'b0;
            jst_sel <= 3'h0;
            st_start <= 1'b0;
            key_accept <= 1'b0;
        end else begin
            gate_start <= cmd_ok && op == `RCE_OP_GATE_START;
            gate_stop <= cmd_ok && op == `RCE_OP_GATE_STOP;
            jst_start <= cmd_ok && op == `RCE_OP_JITTER;
            if (cmd_ok && op == `RCE_OP_JITTER) begin
                jst_sel <= arg[2:0];
            end
            st_start <= cmd_ok && op == `RCE_OP_SELF_TEST;
            key_accept <= key_press & (key_is_power | ~key_locked);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // status byte; every set outranks a clear in the same cycle
    logic clr_all;
    logic fps_reg;
    logic lcl_reg;
    logic err_bit_reg;
    logic rqs_reg;
    logic [7:0] srq_mask_reg;
    logic [7:0] stb;
    assign clr_all = (cmd_ok && op == `RCE_OP_CLEAR) | dev_clear;
    always_comb begin
        stb = {1'b0, rqs_reg, err_bit_reg, ready_in[`RCE_READY_DRO],
               lcl_reg, fps_reg, 2'b00};
        stb[7] = stb_misc_in[2];
        stb[1:0] = stb_misc_in[1:0];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            err_bit_reg <= 1'b0;
            fps_reg <= 1'b0;
            lcl_reg <= 1'b1;
            rqs_reg <= 1'b0;
            srq_mask_reg <= 8'h00;
            srq <= 1'b0;
        end else begin
            if (err_valid) begin
                err_bit_reg <= 1'b1;
            end else if (clr_all) begin
                err_bit_reg <= 1'b0;
            end
            if (key_press && (key_is_power || !key_locked)) begin
                fps_reg <= 1'b1;
            end else if (clr_all) begin
                fps_reg <= 1'b0;
            end
            if (clr_all || stb_rd) begin
                lcl_reg <= 1'b0;
            end
            if (srq) begin
                rqs_reg <= 1'b1;
            end else if (clr_all || stb_rd) begin
                rqs_reg <= 1'b0;
            end
            if (mask_wr) begin
                srq_mask_reg <= avs_writedata[7:0];
            end
            // polling is the only route on the serial link
            srq <= remote_gpib & |(stb & srq_mask_reg);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // query answers; serial query streams ten words through resp
    logic [15:0] resp_reg;
    logic [3:0] seq_left_reg;
    logic [3:0] seq_idx_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resp_reg <= 16'h0000;
            seq_left_reg <= 4'h0;
            seq_idx_reg <= 4'h0;
        end else if (cmd_ok && op == `RCE_OP_SERIAL_QRY) begin
            seq_left_reg <= `RCE_SERIAL_N;
            seq_idx_reg <= 4'h0;
        end else if (cmd_ok) begin
            unique case (op)
                `RCE_OP_LOCK_QRY: resp_reg <= {15'h0000, key_locked};
                `RCE_OP_FW_QRY: resp_reg <= FW_REV;
                `RCE_OP_ADR_QRY: resp_reg <= {11'h000, bus_addr};
                default: resp_reg <= resp_reg;
            endcase
        end else if (resp_rd && seq_left_reg != 4'h0) begin
            seq_left_reg <= seq_left_reg - 4'h1;
            seq_idx_reg <= seq_idx_reg + 4'h1;
        end
    end

    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        unique case (avs_address)
            `RCE_OFS_RESP: rd_val = (seq_left_reg != 4'h0) ?
                serial_reg[seq_idx_reg] : resp_reg;
            `RCE_OFS_ERR: rd_val = q_empty ? 16'h0000 :
                err_mem[rd_ptr_reg[`RCE_ERRQ_AW-1:0]];
            `RCE_OFS_STB: rd_val = {8'h00, stb};
            `RCE_OFS_STA: rd_val = {8'h00, status_a_in};
            `RCE_OFS_ALARM: rd_val = {8'h00, alarm_in};
            `RCE_OFS_READY: rd_val = {8'h00, ready_in};
            `RCE_OFS_SRQ_MASK: rd_val = {8'h00, srq_mask_reg};
            default: rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~take;
            if (take && avs_read) begin
                // error codes read sign extended
                avs_readdata <= (avs_address == `RCE_OFS_ERR) ?
                    {{16{rd_val[15]}}, rd_val} : {16'h0000, rd_val};
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    property p_lock_set;
        @(posedge core_clk) disable iff (rst)
        cmd_go && op == `RCE_OP_LOCK_SET && arg == 16'h0001 |=> key_locked;
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("lock not engaged");

    property p_locked_key;
        @(posedge core_clk) disable iff (rst)
        key_locked && key_press && !key_is_power |=> !key_accept;
    endproperty
    a_locked_key: assert property (p_locked_key)
        else $error("locked key accepted");

    property p_adr_range;
        @(posedge core_clk) disable iff (rst)
        {11'h000, bus_addr} <= `RCE_ADR_MAX;
    endproperty
    a_adr_range: assert property (p_adr_range)
        else $error("bus address above 30");

    property p_adr_gpib;
        @(posedge core_clk) disable iff (rst)
        cmd_go && op == `RCE_OP_ADR_SET && remote_gpib |->
            err_valid && err_code == `RCE_E_RS232_ONLY ##1 $stable(bus_addr);
    endproperty
    a_adr_gpib: assert property (p_adr_gpib)
        else $error("address set over bus not refused");

    property p_crlf;
        @(posedge core_clk) disable iff (rst)
        rx_valid && cr_pend_reg && rx_char != `RCE_LF |-> err_valid;
    endproperty
    a_crlf: assert property (p_crlf)
        else $error("missing line feed not flagged");

    property p_err_bit;
        @(posedge core_clk) disable iff (rst)
        err_valid |=> err_bit_reg ##1
            (err_bit_reg || ($past(clr_all) && !$past(err_valid)));
    endproperty
    a_err_bit: assert property (p_err_bit)
        else $error("error bit not held");

    property p_srq_serial;
        @(posedge core_clk) disable iff (rst)
        !remote_gpib |=> !srq;
    endproperty
    a_srq_serial: assert property (p_srq_serial)
        else $error("service request on serial link");

    property p_jgen_oor;
        @(posedge core_clk) disable iff (rst)
        cmd_go && op == `RCE_OP_JITTER && jgen_oor |=> !jst_start;
    endproperty
    a_jgen_oor: assert property (p_jgen_oor)
        else $error("jitter run with generator out of range");

    property p_gate_busy;
        @(posedge core_clk) disable iff (rst)
        cmd_go && op == `RCE_OP_GATE_START && gating |->
            err_code == `RCE_E_GATING ##1 !gate_start;
    endproperty
    a_gate_busy: assert property (p_gate_busy)
        else $error("start during gating not refused");

    property p_answer;
        @(posedge core_clk) disable iff (rst)
        take |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer not one cycle");

    c_err_pop: cover property (@(posedge core_clk) disable iff (rst)
        q_pop ##1 q_empty);
    c_serial_seq: cover property (@(posedge core_clk) disable iff (rst)
        cmd_ok && op == `RCE_OP_SERIAL_QRY);
    c_q_full: cover property (@(posedge core_clk) disable iff (rst)
        q_full && err_valid);
    c_srq: cover property (@(posedge core_clk) disable iff (rst) srq);

endmodule

/* test/rce_link_model.sv */
// serial character source on the controller side of the link
module rce_link_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bench control
    input wire logic send_cr,
    // character stream
    output logic rx_valid,
    output logic [7:0] rx_char
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] step_reg;
    // idle line toggles so a stale char never looks valid
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            step_reg <= 2'h0;
            rx_valid <= 1'b0;
            rx_char <= 8'h00;
        end else begin
            // bare carriage return, then a char that is no line feed
            rx_valid <= (step_reg != 2'h0);
            rx_char <= (step_reg == 2'h1) ? 8'h0D : (step_reg == 2'h2) ?
                8'h41 : ~rx_char;
            step_reg <= (step_reg == 2'h1) ? 2'h2 : {1'b0, send_cr};
        end
    end
endmodule

/* test/rce_cmd_interp_bench.sv */
// self-checking bench for the remote command interpreter
module rce_cmd_interp_bench;
    import rce_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst = 1, send_cr = 0, avs_read = 0, avs_write = 0;
    logic avs_waitrequest, key_locked, rx_valid, remote_gpib = 0;
    logic rx_parity_err = 0, rx_framing_err = 0, rx_uart_ovr = 0;
    logic rx_ibuf_ovr = 0, cmdbuf_ovf = 0, gating = 0, key_press = 0;
    logic gate_period_zero = 0, start_blocked = 0, jitter_cap = 0;
    logic jgen_oor = 0, hw_fault = 0, rom_csum_fail = 0, dev_clear = 0;
    logic st_done = 0, st_fail = 0, st_power_on = 0, key_is_power = 0;
    logic [5:0] avs_address = 0;
    logic [7:0] rx_char, status_a_in = 0, alarm_in = 0, ready_in = 0;
    logic [2:0] stb_misc_in = 0;
    logic [2:0] jst_sel;
    logic [4:0] bus_addr;
    logic jst_start, srq, flow_sw_rx, flow_sw_tx;
    logic [15:0] st_code = 0, rnd = 16'hC6A3;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [31:0] exp_q[$];
    int error_cnt = 0, comparisons = 0, jst_cnt = 0;
    always #20 core_clk = ~core_clk;
    rce_cmd_interp dut_u (.core_clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .rx_valid, .rx_char, .rx_parity_err, .rx_framing_err, .rx_uart_ovr,
        .rx_ibuf_ovr, .cmdbuf_ovf, .remote_gpib, .gating, .gate_period_zero,
        .start_blocked, .jitter_cap, .jgen_oor, .hw_fault, .rom_csum_fail,
        .dev_clear, .st_done, .st_fail, .st_power_on, .st_code, .status_a_in,
        .alarm_in, .ready_in, .stb_misc_in, .key_press, .key_is_power,
        .key_accept(), .key_locked, .gate_start(), .gate_stop(),
        .jst_start, .jst_sel, .st_start(), .flow_sw_rx, .flow_sw_tx,
        .bus_addr, .srq);
    rce_link_model link_u (.core_clk, .rst, .send_cr, .rx_valid, .rx_char);
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // request held until waitrequest is seen low, then released
    task automatic acc(input logic w, input logic [5:0] a, input [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
        acc(1'b1, 6'h00, {arg, 8'h00, op});
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 32'h0000_0000);
    endtask
    // read data taken at the edge where waitrequest is low
    always @(posedge core_clk)
        if (avs_read && avs_waitrequest === 1'b0)
            chk("readdata", exp_q.pop_front(), avs_readdata);
    always @(posedge core_clk) jst_cnt <= jst_cnt + (jst_start === 1'b1);
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(6'h0C, 32'h0000_0008);
        rd(6'h0C, 32'h0000_0000);
        cmd(8'h03, 16'h0001);
        chk("key_locked", 32'h0000_0001, key_locked);
        key_press <= 1'b1;
        @(posedge core_clk);
        key_press <= 1'b0;
        rd(6'h0C, 32'h0000_0000);
        cmd(8'h04, 16'h0000);
        rd(6'h04, 32'h0000_0001);
        cmd(8'h03, 16'h0000);
        cmd(8'h04, 16'h0000);
        rd(6'h04, 32'h0000_0000);
        cmd(8'h05, 16'h0000);
        rd(6'h04, 32'h0000_08FD);
        cmd(8'h06, 16'h001E);
        cmd(8'h07, 16'h0000);
        rd(6'h04, 32'h0000_001E);
        cmd(8'h06, 16'h001F);
        remote_gpib <= 1'b1;
        cmd(8'h06, 16'h0005);
        chk("bus_addr", 32'h0000_001E, bus_addr);
        remote_gpib <= 1'b0;
        cmd(8'h7F, 16'h0000);
        send_cr <= 1'b1;
        @(posedge core_clk);
        send_cr <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(6'h0C, 32'h0000_0020);
        rd(6'h08, 32'hFFFF_FF2C);
        rd(6'h08, 32'h0000_0260);
        rd(6'h08, 32'hFFFF_FF9C);
        rd(6'h08, 32'hFFFF_FF69);
        rd(6'h08, 32'h0000_0000);
        cmd(8'h0C, 16'h0000);
        rd(6'h0C, 32'h0000_0000);
        acc(1'b1, 6'h00, 32'h0003_0901);
        chk("flow_sw", 32'h0000_0003, {flow_sw_tx, flow_sw_rx});
        cmd(8'h02, 16'h0000);
        for (int i = 0; i < 10; i++)
            rd(6'h04, (i == 9) ? 32'h0000_0003 : 32'h0000_0000);
        jitter_cap <= 1'b1;
        cmd(8'h08, 16'h0004);
        chk("jst_sel", 32'h0000_0004, jst_sel);
        jgen_oor <= 1'b1;
        cmd(8'h08, 16'h0002);
        chk("jst_start", 32'h0000_0001, jst_cnt);
        gating <= 1'b1;
        cmd(8'h0A, 16'h0000);
        {gating, jgen_oor, rx_parity_err} <= 3'b001;
        @(posedge core_clk);
        {rx_parity_err, rom_csum_fail} <= 2'b01;
        @(posedge core_clk);
        {rom_csum_fail, st_done, st_fail, st_code} <= {3'b011, 16'h0190};
        @(posedge core_clk);
        st_power_on <= 1'b1;
        @(posedge core_clk);
        {st_done, st_fail, st_power_on} <= 3'b000;
        remote_gpib <= 1'b1;
        acc(1'b1, 6'h1C, 32'h0000_0020);
        chk("srq", 32'h0000_0001, srq);
        remote_gpib <= 1'b0;
        rd(6'h0C, 32'h0000_0060);
        rd(6'h08, 32'hFFFF_FEFC);
        rd(6'h08, 32'hFFFF_FF06);
        rd(6'h08, 32'hFFFF_FF60);
        rd(6'h08, 32'hFFFF_FEBF);
        rd(6'h08, 32'h0000_0190);
        repeat (4) begin
            rnd = lfsr(rnd);
            status_a_in <= rnd[7:0];
            alarm_in <= rnd[15:8];
            rd(6'h10, {24'h00_0000, rnd[7:0]});
            rd(6'h14, {24'h00_0000, rnd[15:8]});
        end
        end_of_test;
    end
    initial begin
        #100000;
        error_cnt++;
        end_of_test;
    end
endmodule
